//--- rtl/xie_exec.sv
// exclusive-or instruction executor of the core
`timescale 1ns/100ps
`include "xie_map.svh"
// Summary of operation
// - result bit is one where the two operand bits differ
// - direct destination xors any ram byte or register, writes back
// - direct destination mask is immediate or accumulator
// - mask one inverts a bit, mask zero keeps it, ports too
// - opcode 0x65 plus address: accumulator xor direct, 2 bytes, 1 cycle
// - accumulator xor direct puts result in accumulator only
// - six operand combinations for accumulator and direct destinations
// - port destination uses output latch, not pin level
module xie_exec #(
  parameter int STATE_W = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // instruction stream
  input wire logic insn_valid,
  input wire logic [7:0] insn_opcode,
  input wire logic [7:0] insn_byte1,
  input wire logic [7:0] insn_byte2,
  // core state
  input wire logic [7:0] acc_in,
  input wire logic [1:0] bank_sel,
  // operand read answers
  input wire logic [7:0] ram_rdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] port_one_latch,
  input wire logic [7:0] port_one_pins,
  // operand read request
  output logic rd_req,
  output logic [7:0] rd_addr,
  // write back
  output logic acc_we,
  output logic [7:0] acc_wdata,
  output logic mem_we,
  output logic [7:0] mem_addr,
  output logic [7:0] mem_wdata,
  // status
  output logic busy,
  output logic done,
  output logic illegal
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PTR,
    ST_FETCH,
    ST_EXEC,
    ST_HOLD
  } st_t;
  typedef struct packed {
    st_t st;
    xie_pkg::xie_dec_t dec;
    logic [7:0] addr;
    logic [7:0] imm;
    logic [7:0] acc;
    logic [7:0] opnd;
    logic [STATE_W-1:0] states;
    logic rd_req;
    logic [7:0] rd_addr;
    logic acc_we;
    logic [7:0] acc_wdata;
    xie_pkg::xie_wr_t wr;
    logic busy;
    logic done;
    logic illegal;
  } state_t;
  state_t s_q;
  state_t s_d;
  xie_pkg::xie_dec_t dec_w;
  logic [7:0] opnd_w;

  xie_decode u_dec (
    .opcode(insn_opcode),
    .dec(dec_w)
  );

  function automatic logic [7:0] bank_addr(input logic [1:0] bank,
                                           input logic [2:0] idx);
    bank_addr = {3'h0, bank, idx};
  endfunction

  function automatic logic [STATE_W-1:0] state_limit(
      input logic [1:0] cycles);
    state_limit = STATE_W'({2'h0, cycles} * `XIE_STATES_PER_CYCLE -
                           `XIE_HOLD_LEAD);
  endfunction

  function automatic logic mask_is_imm(input xie_pkg::xie_dec_t dec);
    mask_is_imm = (dec.src == xie_pkg::XIE_SRC_IMM);
  endfunction

  // port destination reads latch, source reads pins
  always_comb begin
    if (s_q.rd_addr == `XIE_PORT_ONE_ADDR &&
        s_q.dec.src != xie_pkg::XIE_SRC_IND) begin
      opnd_w = (s_q.dec.dst == xie_pkg::XIE_DST_DIR) ? port_one_latch :
               port_one_pins;
    end else if (s_q.rd_addr >= `XIE_SFR_BASE &&
                 s_q.dec.src != xie_pkg::XIE_SRC_IND) begin
      opnd_w = reg_rdata;
    end else begin
      opnd_w = ram_rdata;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.rd_req = 1'b0;
    s_d.acc_we = 1'b0;
    s_d.wr.we = 1'b0;
    s_d.done = 1'b0;
    s_d.illegal = 1'b0;
    // count states from the accepting edge
    if (s_q.st != ST_IDLE) begin
      s_d.states = s_q.states + STATE_W'(1);
    end
    case (s_q.st)
      ST_IDLE: begin
        s_d.busy = 1'b0;
        if (insn_valid) begin
          s_d.dec = dec_w;
          s_d.acc = acc_in;
          s_d.addr = insn_byte1;
          s_d.imm = (dec_w.bytes == 2'h3) ? insn_byte2 : insn_byte1;
          s_d.states = '0;
          if (!dec_w.valid) begin
            s_d.illegal = 1'b1;
          end else begin
            s_d.busy = 1'b1;
            s_d.rd_req = 1'b1;
            case (dec_w.src)
              xie_pkg::XIE_SRC_REG: begin
                s_d.rd_addr = bank_addr(bank_sel, insn_opcode[2:0]);
                s_d.st = ST_FETCH;
              end
              xie_pkg::XIE_SRC_IND: begin
                s_d.rd_addr = bank_addr(bank_sel, {2'h0, insn_opcode[0]});
                s_d.st = ST_PTR;
              end
              xie_pkg::XIE_SRC_DIR: begin
                s_d.rd_addr = insn_byte1;
                s_d.st = ST_FETCH;
              end
              xie_pkg::XIE_SRC_IMM: begin
                s_d.rd_req = (dec_w.dst == xie_pkg::XIE_DST_DIR);
                s_d.rd_addr = insn_byte1;
                s_d.opnd = acc_in;
                s_d.st = (dec_w.dst == xie_pkg::XIE_DST_DIR) ?
                         ST_FETCH : ST_EXEC;
              end
              default: begin
                s_d.rd_addr = insn_byte1;
                s_d.st = ST_FETCH;
              end
            endcase
          end
        end
      end
      ST_PTR: begin
        s_d.rd_req = 1'b1;
        s_d.rd_addr = ram_rdata;
        s_d.st = ST_FETCH;
      end
      ST_FETCH: begin
        s_d.opnd = opnd_w;
        s_d.st = ST_EXEC;
      end
      ST_EXEC: begin
        if (s_q.dec.dst == xie_pkg::XIE_DST_DIR) begin
          s_d.wr.we = 1'b1;
          s_d.wr.addr = s_q.addr;
          s_d.wr.data = s_q.opnd ^ (mask_is_imm(s_q.dec) ?
                                    s_q.imm : s_q.acc);
        end else begin
          s_d.acc_we = 1'b1;
          s_d.acc_wdata = s_q.acc ^ (mask_is_imm(s_q.dec) ?
                                     s_q.imm : s_q.opnd);
        end
        s_d.st = ST_HOLD;
      end
      ST_HOLD: begin
        // pad to six states per cycle
        if (s_q.states >= state_limit(s_q.dec.cycles)) begin
          s_d.done = 1'b1;
          s_d.busy = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_req = s_q.rd_req;
  assign rd_addr = s_q.rd_addr;
  assign acc_we = s_q.acc_we;
  assign acc_wdata = s_q.acc_wdata;
  assign mem_we = s_q.wr.we;
  assign mem_addr = s_q.wr.addr;
  assign mem_wdata = s_q.wr.data;
  assign busy = s_q.busy;
  assign done = s_q.done;
  assign illegal = s_q.illegal;
endmodule

//--- rtl/xie_map.svh
// opcode encodings, field positions and timing counts of the xor executor
`ifndef XIE_MAP_SVH
`define XIE_MAP_SVH
`define XIE_OP_DIR_A 8'h62
`define XIE_OP_DIR_IMM 8'h63
`define XIE_OP_A_IMM 8'h64
`define XIE_OP_A_DIR 8'h65
`define XIE_OP_IND_HI 7'h33
`define XIE_OP_REG_HI 5'h0D
`define XIE_STATES_PER_CYCLE 3'h6
`define XIE_HOLD_LEAD 4'h2
`define XIE_SFR_BASE 8'h80
`define XIE_PORT_ONE_ADDR 8'h90
`endif

//--- rtl/xie_pkg.sv
// types shared by the xor executor
package xie_pkg;
  typedef enum logic [1:0] {
    XIE_DST_ACC,
    XIE_DST_DIR
  } xie_dst_t;
  typedef enum logic [2:0] {
    XIE_SRC_REG,
    XIE_SRC_IND,
    XIE_SRC_DIR,
    XIE_SRC_IMM,
    XIE_SRC_ACC
  } xie_src_t;
  typedef struct packed {
    logic valid;
    xie_dst_t dst;
    xie_src_t src;
    logic [1:0] bytes;
    logic [1:0] cycles;
  } xie_dec_t;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } xie_wr_t;
endpackage

//--- rtl/xie_decode.sv
// opcode decoder for the exclusive-or instruction family
`timescale 1ns/100ps
`include "xie_map.svh"
module xie_decode (
  // opcode in
  input wire logic [7:0] opcode,
  // decoded form out
  output xie_pkg::xie_dec_t dec
);
  always_comb begin
    dec = '0;
    dec.dst = xie_pkg::XIE_DST_ACC;
    dec.src = xie_pkg::XIE_SRC_REG;
    dec.bytes = 2'h1;
    dec.cycles = 2'h1;
    if (opcode == `XIE_OP_DIR_A) begin
      dec.valid = 1'b1;
      dec.dst = xie_pkg::XIE_DST_DIR;
      dec.src = xie_pkg::XIE_SRC_ACC;
      dec.bytes = 2'h2;
    end else if (opcode == `XIE_OP_DIR_IMM) begin
      dec.valid = 1'b1;
      dec.dst = xie_pkg::XIE_DST_DIR;
      dec.src = xie_pkg::XIE_SRC_IMM;
      dec.bytes = 2'h3;
      dec.cycles = 2'h2;
    end else if (opcode == `XIE_OP_A_IMM) begin
      dec.valid = 1'b1;
      dec.src = xie_pkg::XIE_SRC_IMM;
      dec.bytes = 2'h2;
    end else if (opcode == `XIE_OP_A_DIR) begin
      dec.valid = 1'b1;
      dec.src = xie_pkg::XIE_SRC_DIR;
      dec.bytes = 2'h2;
    end else if (opcode[7:1] == `XIE_OP_IND_HI) begin
      dec.valid = 1'b1;
      dec.src = xie_pkg::XIE_SRC_IND;
    end else if (opcode[7:3] == `XIE_OP_REG_HI) begin
      dec.valid = 1'b1;
      dec.src = xie_pkg::XIE_SRC_REG;
    end
  end
endmodule

//--- verification/xie_exec_assertions.sv
// assertion checker of the xor executor
`timescale 1ns/100ps
module xie_exec_chk (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // instruction in
  input wire logic insn_valid,
  input wire logic [7:0] insn_opcode,
  input wire logic [7:0] insn_byte1,
  input wire logic [7:0] acc_in,
  input wire logic [1:0] bank_sel,
  // results out
  input wire logic rd_req,
  input wire logic [7:0] rd_addr,
  input wire logic acc_we,
  input wire logic [7:0] acc_wdata,
  input wire logic mem_we,
  input wire logic [7:0] mem_addr,
  input wire logic busy,
  input wire logic done,
  input wire logic illegal
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  wire take = insn_valid && !busy;
  wire [7:0] op = insn_opcode;
  property p_acc_dir;
    take && op == 8'h65 |=> rd_req && rd_addr == $past(insn_byte1)
      ##2 acc_we && !mem_we;
  endproperty
  a_acc_dir: assert property (p_acc_dir) else $error("acc dir form");
  property p_a_imm;
    take && op == 8'h64 |=> !rd_req
      ##1 acc_we && acc_wdata == ($past(acc_in, 2) ^ $past(insn_byte1, 2));
  endproperty
  a_a_imm: assert property (p_a_imm) else $error("acc imm result");
  property p_dir_a;
    take && op == 8'h62 |-> ##3 mem_we && !acc_we
      && mem_addr == $past(insn_byte1, 3);
  endproperty
  a_dir_a: assert property (p_dir_a) else $error("dir write back");
  property p_dir_imm;
    take && op == 8'h63 |-> ##12 done;
  endproperty
  a_dir_imm: assert property (p_dir_imm) else $error("dir imm time");
  property p_one_cyc;
    take && op inside {[8'h62:8'h6F]} && op != 8'h63 |-> ##6 done;
  endproperty
  a_one_cyc: assert property (p_one_cyc) else $error("done time");
  property p_illegal;
    take && (op < 8'h62 || op > 8'h6F) |=> illegal && !rd_req;
  endproperty
  a_illegal: assert property (p_illegal) else $error("no illegal");
  property p_reg;
    take && op[7:3] == 5'h0D |=>
      rd_addr == ({3'h0, $past(bank_sel), 3'h0} | ($past(op) & 8'h07));
  endproperty
  a_reg: assert property (p_reg) else $error("bank reg addr");
  property p_ind;
    take && op[7:1] == 7'h33 |=>
      rd_addr == ({3'h0, $past(bank_sel), 3'h0} | ($past(op) & 8'h01))
      ##3 acc_we;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect form");
  property p_excl;
    !(acc_we && mem_we);
  endproperty
  a_excl: assert property (p_excl) else $error("two writes");
  c_imm: cover property (take && op == 8'h63);
  c_ill: cover property (illegal);
  c_port: cover property (mem_we && mem_addr == 8'h90);
endmodule
bind xie_exec xie_exec_chk u_chk (.clock, .resetn, .insn_valid,
  .insn_opcode, .insn_byte1, .acc_in, .bank_sel, .rd_req, .rd_addr,
  .acc_we, .acc_wdata, .mem_we, .mem_addr, .busy, .done, .illegal);

//--- verification/xie_exec_tb.sv
// self-checking bench of the xor executor
`timescale 1ns/100ps
module xie_exec_tb;
  logic clock = 0;
  logic resetn = 0;
  logic insn_valid = 0;
  logic [7:0] insn_opcode = 8'h00, insn_byte1 = 8'h00, insn_byte2 = 8'h00;
  logic [7:0] acc_in = 8'h00, port_one_latch = 8'hC4;
  logic [1:0] bank_sel = 2'h0;
  logic [7:0] mem [256];
  logic [7:0] ram_rdata, reg_rdata, port_one_pins, rd_addr, acc_wdata;
  logic [7:0] mem_addr, mem_wdata, acc_res, mem_res, mem_at;
  logic rd_req, acc_we, mem_we, busy, done, illegal;
  int err_count = 0, num_checks = 0, n_acc, n_mem, cyc = 0;
  assign ram_rdata = mem[rd_addr];
  // register space reads the inverse of ram
  assign reg_rdata = ~mem[rd_addr];
  assign port_one_pins = ~port_one_latch;
  xie_exec u_dut (.clock, .resetn, .insn_valid, .insn_opcode, .insn_byte1,
    .insn_byte2, .acc_in, .bank_sel, .ram_rdata, .reg_rdata,
    .port_one_latch, .port_one_pins, .rd_req, .rd_addr, .acc_we,
    .acc_wdata, .mem_we, .mem_addr, .mem_wdata, .busy, .done, .illegal);
  initial forever #25 clock = ~clock;
  always @(negedge clock) begin
    cyc++;
    if (acc_we === 1'b1) begin
      acc_res = acc_wdata;
      n_acc++;
    end
    if (mem_we === 1'b1) begin
      mem_res = mem_wdata;
      mem_at = mem_addr;
      n_mem++;
    end
    if (cyc == 1000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic run(input logic [7:0] op, b1, b2, a, n_exp);
    logic [7:0] n;
    @(negedge clock);
    n_acc = 0;
    n_mem = 0;
    {insn_opcode, insn_byte1, insn_byte2, acc_in} = {op, b1, b2, a};
    insn_valid = 1;
    @(negedge clock);
    insn_valid = 0;
    n = 0;
    while (done !== 1'b1 && illegal !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    check(n, n_exp);
  endtask
  task automatic t_acc_reg();
    bank_sel = 2'h2;
    mem[8'h10] = 8'hAA;
    run(8'h68, 8'h00, 8'h00, 8'hC3, 8'h05);
    check(acc_res, 8'h69);
  endtask
  task automatic t_acc_dir();
    mem[8'h30] = 8'h5A;
    run(8'h65, 8'h30, 8'h00, 8'h0F, 8'h05);
    check(acc_res, 8'h55);
    check(8'(n_mem), 8'h00);
  endtask
  task automatic t_port();
    run(8'h63, 8'h90, 8'h31, 8'h00, 8'h0B);
    check(mem_at, 8'h90);
    check(mem_res, 8'hF5);
    check(8'(n_acc), 8'h00);
  endtask
  task automatic t_sfr();
    mem[8'h85] = 8'hC3;
    run(8'h62, 8'h85, 8'h00, 8'hFF, 8'h05);
    check(mem_res, 8'hC3);
  endtask
  task automatic t_ind();
    bank_sel = 2'h1;
    mem[8'h09] = 8'h40;
    mem[8'h40] = 8'h12;
    run(8'h67, 8'h00, 8'h00, 8'h21, 8'h05);
    check(acc_res, 8'h33);
  endtask
  task automatic t_misc();
    run(8'h64, 8'hF0, 8'h00, 8'h0F, 8'h05);
    check(acc_res, 8'hFF);
    run(8'h65, 8'h90, 8'h00, 8'h00, 8'h05);
    check(acc_res, 8'h3B);
    run(8'h70, 8'h00, 8'h00, 8'h00, 8'h00);
    check(8'(n_acc + n_mem), 8'h00);
  endtask
  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i);
    repeat (4) @(negedge clock);
    resetn = 1;
    t_acc_reg();
    t_acc_dir();
    t_port();
    t_sfr();
    t_ind();
    t_misc();
    end_sim();
  end
endmodule
